// File: cal_timer.sv
// Down counter that times one calibration or one abort
`timescale 1ns/1ps
`default_nettype none
module cal_timer #(
	parameter int unsigned W = 17
) (
	input wire logic clk,
	input wire logic rst,
	cal_timer_if.timer tif
);
	logic [W-1:0] remain;
	logic [W-1:0] next_remain;
	logic expire;
	logic next_expire;

	always_comb begin
		next_remain = remain;
		next_expire = 1'b0;
		if (tif.load) begin
			next_remain = tif.count;
		end else if (remain != '0) begin
			next_remain = remain - W'(1);
			next_expire = (remain == W'(1));
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remain <= '0;
			expire <= 1'b0;
		end else begin
			remain <= next_remain;
			expire <= next_expire;
		end
	end

	assign tif.expire = expire;
	assign tif.busy = (remain != '0);
endmodule // cal_timer
`default_nettype wire

// File: cal_timer_if.sv
// Load/expire handshake between the calibration sequencer and its timer
`timescale 1ns/1ps
`default_nettype none
interface cal_timer_if #(parameter int unsigned W = 17);
	logic load;
	logic [W-1:0] count;
	logic expire;
	logic busy;
	modport ctrl(output load, output count, input expire, input busy);
	modport timer(input load, input count, output expire, output busy);
endinterface
`default_nettype wire

// File: low_speed_clock_select_calibration_tb.sv
// Self-checking bench for the low-speed clock control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module low_speed_clock_select_calibration_tb;
	localparam int unsigned CALC = 40;
	localparam int unsigned ABRT = 10;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, xs = 1'b0, rs = 1'b1;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, perr, lsx, src, lss, sys_rc, cal, caled, pm_en, tick;
	logic [10:0] ratio;
	logic [2:0] sdiv, tdiv;
	logic [1:0] pm;
	int err_total = 0, checks_done = 0, cyc = 0, n = 0;
	lsclk_ctrl #(.SECOND_VARIANT(1'b0), .CAL_CYCLES(CALC), .ABORT_CYCLES(ABRT)) i_dut (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_crystal_stable_flag(xs),
		.fast_rc_stable_flag(rs), .low_speed_crystal_enable(lsx), .slow_rc_enable(src),
		.low_speed_source_select(lss), .system_clock_is_rc(sys_rc), .calibration_active(cal),
		.slow_rc_calibrated(caled), .slow_rc_ratio(ratio), .system_clock_divider(sdiv),
		.timer_tick_divider(tdiv), .timer_tick(tick), .power_mode_enter(pm_en), .power_mode(pm));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata; perr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask
	// Sampled at the edge, so values seen are those settled before it
	task automatic wait_for(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin @(posedge clk); n++; end
		if (n >= lim) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, s, v); end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic t_reset();
		apb(1'b0, 12'h318, 8'h0); `CHK(q[7:0], 8'hc9)
		`CHK({src, lsx, sys_rc}, 3'b101)
		`CHK(ratio, 11'h2ee)
		apb(1'b0, 12'h3fc, 8'h0); `CHK(perr, 1'b1)
		apb(1'b1, 12'h318, 8'h49); `CHK({src, lsx, lss}, 3'b010)
		apb(1'b1, 12'h318, 8'hc9); `CHK({src, lsx, lss}, 3'b101)
		$display("test reset done");
	endtask
	task automatic t_initial();
		apb(1'b1, 12'h318, 8'h89); repeat (10) @(posedge clk);
		`CHK(sys_rc, 1'b1)
		// Fast RC drops out so the return switch must wait for it
		rs <= 1'b0;
		xs <= 1'b1; wait_for(sys_rc, 1'b0, 20); `CHK(sys_rc, 1'b0)
		wait_for(cal, 1'b1, 10); `CHK(cal, 1'b1)
		// Request back to fast RC while the uninterruptible pass runs
		apb(1'b1, 12'h318, 8'hc9); repeat (20) @(posedge clk);
		`CHK({cal, sys_rc}, 2'b10)
		repeat (30) @(posedge clk);
		`CHK(sys_rc, 1'b0)
		rs <= 1'b1;
		wait_for(sys_rc, 1'b1, 60); `CHK({caled, cal}, 2'b10)
		$display("test initial done");
	endtask
	task automatic t_abort();
		apb(1'b1, 12'h318, 8'h89); wait_for(cal, 1'b1, 20); wait_for(cal, 1'b0, 60);
		wait_for(cal, 1'b1, 5); `CHK(cal, 1'b1)
		apb(1'b0, 12'h31c, 8'h0); `CHK(q[2], 1'b1)
		apb(1'b1, 12'h320, 8'h02); wait_for(pm_en, 1'b1, 40);
		`CHK(n >= ABRT - 2 && n <= ABRT + 4, 1'b1)
		@(posedge clk); `CHK(pm, 2'h2)
		apb(1'b1, 12'h318, 8'hc9); wait_for(sys_rc, 1'b1, 100); `CHK(sys_rc, 1'b1)
		$display("test abort done");
	endtask
	task automatic t_tick();
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, 12'h318, {2'b11, d[2:0], 3'b000}); `CHK(tdiv, (d == 0) ? 3'h1 : d[2:0])
			`CHK(sdiv, 3'h1)
			wait_for(tick, 1'b1, 20); @(posedge clk); wait_for(tick, 1'b1, 20);
			`CHK(n + 1, (d == 0) ? 2 : (1 << d))
		end
		$display("test tick done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_initial();
		t_abort();
		t_tick();
		results();
	end
endmodule // low_speed_clock_select_calibration_tb
`default_nettype wire

// File: lsclk_ctrl.sv
// Low-speed clock source select, slow RC calibration sequencing and clock control register
`timescale 1ns/1ps
`default_nettype none
module lsclk_ctrl #(
	parameter bit SECOND_VARIANT = 1'b0,
	parameter int unsigned CAL_CYCLES = lsclk_pkg::CAL_CYCLES,
	parameter int unsigned ABORT_CYCLES = lsclk_pkg::ABORT_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lsclk_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fast_crystal_stable_flag,
	input wire logic fast_rc_stable_flag,
	output logic low_speed_crystal_enable,
	output logic slow_rc_enable,
	output logic low_speed_source_select,
	output logic system_clock_is_rc,
	output logic calibration_active,
	output logic slow_rc_calibrated,
	output logic [lsclk_pkg::RATIO_W-1:0] slow_rc_ratio,
	output logic [lsclk_pkg::DIV_W-1:0] system_clock_divider,
	output logic [lsclk_pkg::DIV_W-1:0] timer_tick_divider,
	output logic timer_tick,
	output logic power_mode_enter,
	output logic [lsclk_pkg::PM_MODE_W-1:0] power_mode
);
	localparam int unsigned TW = lsclk_pkg::TIMER_W;
	localparam int unsigned DW = lsclk_pkg::DIV_W;
	localparam int unsigned PW = lsclk_pkg::PM_MODE_W;

	function automatic logic hits(input logic [lsclk_pkg::ADDR_W-1:0] a, input logic [11:0] index);
		hits = (a == lsclk_pkg::ADDR_W'({index, 2'b00}));
	endfunction

	// On fast RC the undivided setting is unavailable; treat it as the next one
	function automatic logic [DW-1:0] usable_div(input logic [DW-1:0] d, input logic on_rc);
		usable_div = (on_rc && d == '0) ? lsclk_pkg::DIV_LOWEST_ON_RC : d;
	endfunction

	// Stability flags come from the analog oscillators
	logic xtal_meta, xtal_stable, rcfast_meta, rcfast_stable;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xtal_meta <= 1'b0;
			xtal_stable <= 1'b0;
			rcfast_meta <= 1'b0;
			rcfast_stable <= 1'b0;
		end else begin
			xtal_meta <= fast_crystal_stable_flag;
			xtal_stable <= xtal_meta;
			rcfast_meta <= fast_rc_stable_flag;
			rcfast_stable <= rcfast_meta;
		end
	end

	// Register bus decode
	logic access, wr_ctl, wr_pm, rd_hit;
	logic [7:0] status;

	assign access = psel && penable;
	assign wr_ctl = access && pwrite && pstrb[0] && hits(paddr, lsclk_pkg::CLOCK_CONTROL_INDEX);
	assign wr_pm = access && pwrite && pstrb[0] && hits(paddr, lsclk_pkg::POWER_REQUEST_INDEX);
	assign rd_hit = hits(paddr, lsclk_pkg::CLOCK_CONTROL_INDEX) || hits(paddr, lsclk_pkg::CAL_STATUS_INDEX)
		|| hits(paddr, lsclk_pkg::POWER_REQUEST_INDEX);
	assign pready = 1'b1;
	assign pslverr = access && !rd_hit;

	// Control state
	logic [7:0] clock_control, next_clock_control;
	logic active_rc, next_active_rc;
	logic init_done, next_init_done;
	logic calibrated, next_calibrated;
	logic pm_pending, next_pm_pending;
	logic [PW-1:0] pm_mode, next_pm_mode;
	logic pm_enter, next_pm_enter;
	logic [31:0] rdata, next_rdata;
	lsclk_pkg::cal_state_t cal_state, next_cal_state;

	cal_timer_if #(.W(TW)) tif();

	cal_timer #(
		.W(TW)
	) u_cal_timer (
		.clk(clk),
		.rst(rst),
		.tif(tif)
	);

	logic lss_rc, want_rc, want_xtal, want_deep, may_calibrate;

	assign lss_rc = clock_control[lsclk_pkg::LOW_SPEED_SELECT_BIT];
	assign want_rc = clock_control[lsclk_pkg::SYSTEM_SOURCE_BIT] && !active_rc;
	assign want_xtal = !clock_control[lsclk_pkg::SYSTEM_SOURCE_BIT] && active_rc;
	assign want_deep = pm_pending;
	assign may_calibrate = !active_rc && xtal_stable && lss_rc;

	always_comb begin
		next_clock_control = clock_control;
		next_active_rc = active_rc;
		next_init_done = init_done;
		next_calibrated = calibrated;
		next_pm_pending = pm_pending;
		next_pm_mode = pm_mode;
		next_pm_enter = 1'b0;
		next_cal_state = cal_state;
		tif.load = 1'b0;
		tif.count = '0;

		// Bits 7 and 6 are written as given; software keeps bit 7 still off fast RC
		if (wr_ctl) begin
			next_clock_control = pwdata[7:0];
		end
		if (wr_pm && pwdata[PW-1:0] != '0) begin
			next_pm_pending = 1'b1;
			next_pm_mode = pwdata[lsclk_pkg::PM_MODE_LSB +: PW];
		end

		case (cal_state)
			lsclk_pkg::cal_idle: begin
				if (want_xtal) begin
					if (xtal_stable) begin
						next_active_rc = 1'b0;
						next_init_done = 1'b0;
					end
				end else if (want_rc) begin
					if (rcfast_stable) begin
						next_active_rc = 1'b1;
					end
				end else if (want_deep) begin
					next_pm_enter = 1'b1;
					next_pm_pending = 1'b0;
					// Waking on the crystal calibrates afresh
					next_init_done = 1'b0;
				end else if (may_calibrate) begin
					tif.load = 1'b1;
					tif.count = TW'(CAL_CYCLES);
					next_cal_state = init_done ? lsclk_pkg::cal_repeat : lsclk_pkg::cal_initial;
				end
			end
			lsclk_pkg::cal_initial: begin
				// Requests are held here until the calibration ends
				if (tif.expire) begin
					next_init_done = 1'b1;
					next_calibrated = 1'b1;
					next_cal_state = lsclk_pkg::cal_idle;
				end
			end
			lsclk_pkg::cal_repeat: begin
				if (want_rc || want_deep) begin
					tif.load = 1'b1;
					tif.count = TW'(ABORT_CYCLES);
					next_cal_state = lsclk_pkg::cal_abort;
				end else if (tif.expire) begin
					next_calibrated = 1'b1;
					next_cal_state = lsclk_pkg::cal_idle;
				end
			end
			lsclk_pkg::cal_abort: begin
				if (tif.expire) begin
					next_cal_state = lsclk_pkg::cal_idle;
				end
			end
			default: begin
				next_cal_state = lsclk_pkg::cal_idle;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clock_control <= lsclk_pkg::CLOCK_CONTROL_RESET;
			active_rc <= 1'b1;
			init_done <= 1'b0;
			calibrated <= 1'b0;
			pm_pending <= 1'b0;
			pm_mode <= '0;
			pm_enter <= 1'b0;
			cal_state <= lsclk_pkg::cal_idle;
		end else begin
			clock_control <= next_clock_control;
			active_rc <= next_active_rc;
			init_done <= next_init_done;
			calibrated <= next_calibrated;
			pm_pending <= next_pm_pending;
			pm_mode <= next_pm_mode;
			pm_enter <= next_pm_enter;
			cal_state <= next_cal_state;
		end
	end

	// Read data
	always_comb begin
		status = '0;
		status[lsclk_pkg::ST_ACTIVE_RC_BIT] = active_rc;
		status[lsclk_pkg::ST_CAL_BUSY_BIT] = (cal_state != lsclk_pkg::cal_idle);
		status[lsclk_pkg::ST_INIT_DONE_BIT] = init_done;
		status[lsclk_pkg::ST_CALIBRATED_BIT] = calibrated;
		status[lsclk_pkg::ST_XTAL_STABLE_BIT] = xtal_stable;
		status[lsclk_pkg::ST_RC_STABLE_BIT] = rcfast_stable;
		status[lsclk_pkg::ST_ABORTING_BIT] = (cal_state == lsclk_pkg::cal_abort);
		status[lsclk_pkg::ST_PM_PENDING_BIT] = pm_pending;
		next_rdata = '0;
		if (psel && !penable && !pwrite) begin
			if (hits(paddr, lsclk_pkg::CLOCK_CONTROL_INDEX)) begin
				next_rdata = {24'h000000, clock_control};
			end else if (hits(paddr, lsclk_pkg::CAL_STATUS_INDEX)) begin
				next_rdata = {24'h000000, status};
			end else if (hits(paddr, lsclk_pkg::POWER_REQUEST_INDEX)) begin
				next_rdata = {30'h0, pm_mode};
			end
		end else if (psel) begin
			next_rdata = rdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign prdata = rdata;

	// Timer tick, divided from the reference clock
	logic [DW-1:0] tick_div_eff;

	assign tick_div_eff = usable_div(clock_control[lsclk_pkg::TICK_DIV_LSB +: DW], active_rc);

	tick_prescaler #(
		.DW(DW)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.shift(tick_div_eff),
		.tick(timer_tick)
	);

	// Only one low-speed oscillator may run
	assign slow_rc_enable = lss_rc;
	assign low_speed_crystal_enable = !lss_rc;
	assign low_speed_source_select = lss_rc;

	assign system_clock_is_rc = active_rc;
	assign calibration_active = (cal_state == lsclk_pkg::cal_initial) || (cal_state == lsclk_pkg::cal_repeat);
	assign slow_rc_calibrated = calibrated;
	assign slow_rc_ratio = SECOND_VARIANT ? lsclk_pkg::RATIO_W'(lsclk_pkg::RC_RATIO_SECOND)
		: lsclk_pkg::RATIO_W'(lsclk_pkg::RC_RATIO_FIRST);
	assign system_clock_divider = usable_div(clock_control[lsclk_pkg::SYS_DIV_LSB +: DW], active_rc);
	assign timer_tick_divider = tick_div_eff;
	assign power_mode_enter = pm_enter;
	assign power_mode = pm_mode;
endmodule // lsclk_ctrl
`default_nettype wire

// File: lsclk_ctrl_sva.sv
// Port-level assertions for the low-speed clock control block
`timescale 1ns/1ps
`default_nettype none
module lsclk_ctrl_sva #(
	parameter bit SECOND_VARIANT = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [lsclk_pkg::ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic low_speed_crystal_enable,
	input wire logic slow_rc_enable,
	input wire logic low_speed_source_select,
	input wire logic system_clock_is_rc,
	input wire logic calibration_active,
	input wire logic slow_rc_calibrated,
	input wire logic [lsclk_pkg::RATIO_W-1:0] slow_rc_ratio,
	input wire logic [lsclk_pkg::DIV_W-1:0] timer_tick_divider,
	input wire logic timer_tick,
	input wire logic power_mode_enter
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic mapped;
	assign mapped = paddr inside {12'h318, 12'h31c, 12'h320};
	osc_exclusive_a: assert property (!(low_speed_crystal_enable && slow_rc_enable)) else $error("both osc on");
	sel_follows_a: assert property (slow_rc_enable == low_speed_source_select) else $error("select mismatch");
	ratio_value_a: assert property (slow_rc_ratio == (SECOND_VARIANT ? 11'h5dc : 11'h2ee)) else $error("bad ratio");
	cal_on_xtal_a: assert property (calibration_active |-> !system_clock_is_rc && slow_rc_enable) else $error("bad cal");
	bus_decode_a: assert property (psel && penable |-> pready && (pslverr == !mapped)) else $error("bad decode");
	switch_after_cal_a: assert property ($rose(system_clock_is_rc) |-> !$past(calibration_active))
		else $error("switch during cal");
	pm_grant_pulse_a: assert property (power_mode_enter |-> !$past(calibration_active) ##1 !power_mode_enter)
		else $error("bad grant");
	cal_sticky_a: assert property (slow_rc_calibrated |=> slow_rc_calibrated) else $error("calibrated lost");
	reset_state_a: assert property ($fell(rst) |-> slow_rc_enable && system_clock_is_rc) else $error("bad reset");
	tick_two_a: assert property ((timer_tick && timer_tick_divider == 3'h1) ##1 (timer_tick_divider == 3'h1)[*2]
		|-> timer_tick && !$past(timer_tick)) else $error("bad tick");
	cover property ($rose(calibration_active));
	cover property ($rose(system_clock_is_rc));
	cover property (power_mode_enter);
endmodule // lsclk_ctrl_sva
bind lsclk_ctrl lsclk_ctrl_sva #(.SECOND_VARIANT(SECOND_VARIANT)) i_sva (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.low_speed_crystal_enable(low_speed_crystal_enable), .slow_rc_enable(slow_rc_enable),
	.low_speed_source_select(low_speed_source_select), .system_clock_is_rc(system_clock_is_rc),
	.calibration_active(calibration_active), .slow_rc_calibrated(slow_rc_calibrated),
	.slow_rc_ratio(slow_rc_ratio), .timer_tick_divider(timer_tick_divider), .timer_tick(timer_tick),
	.power_mode_enter(power_mode_enter));
`default_nettype wire

// File: lsclk_pkg.sv
// Constants and types shared by the low-speed clock control files
`default_nettype none
package lsclk_pkg;

	// Register indices; byte address is four times the index
	localparam logic [11:0] CLOCK_CONTROL_INDEX = 12'h0c6;
	localparam logic [11:0] CAL_STATUS_INDEX = 12'h0c7;
	localparam logic [11:0] POWER_REQUEST_INDEX = 12'h0c8;
	localparam int unsigned ADDR_W = 12;

	// clock_control fields
	localparam int unsigned LOW_SPEED_SELECT_BIT = 7;
	localparam int unsigned SYSTEM_SOURCE_BIT = 6;
	localparam int unsigned TICK_DIV_LSB = 3;
	localparam int unsigned SYS_DIV_LSB = 0;
	localparam int unsigned DIV_W = 3;
	localparam logic [7:0] CLOCK_CONTROL_RESET = 8'hc9;
	localparam logic [2:0] DIV_LOWEST_ON_RC = 3'h1;

	// cal_status fields (read only)
	localparam int unsigned ST_ACTIVE_RC_BIT = 0;
	localparam int unsigned ST_CAL_BUSY_BIT = 1;
	localparam int unsigned ST_INIT_DONE_BIT = 2;
	localparam int unsigned ST_CALIBRATED_BIT = 3;
	localparam int unsigned ST_XTAL_STABLE_BIT = 4;
	localparam int unsigned ST_RC_STABLE_BIT = 5;
	localparam int unsigned ST_ABORTING_BIT = 6;
	localparam int unsigned ST_PM_PENDING_BIT = 7;

	// power_request fields
	localparam int unsigned PM_MODE_LSB = 0;
	localparam int unsigned PM_MODE_W = 2;

	// Timing
	localparam int unsigned CLK_FREQ_HZ = 40_000_000;
	localparam int unsigned CAL_TIME_US = 2000;
	localparam int unsigned ABORT_TIME_US = 130;
	localparam int unsigned CAL_CYCLES = CAL_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned ABORT_CYCLES = ABORT_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned TIMER_W = 17;

	// Calibrated slow RC ratio to the fast crystal, per variant
	localparam int unsigned RC_RATIO_FIRST = 750;
	localparam int unsigned RC_RATIO_SECOND = 1500;
	localparam int unsigned RATIO_W = 11;

	typedef enum logic [1:0] {
		cal_idle,
		cal_initial,
		cal_repeat,
		cal_abort
	} cal_state_t;

endpackage
`default_nettype wire

// File: tick_prescaler.sv
// Timer tick generator: one pulse every two-to-the-n reference cycles
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler #(
	parameter int unsigned DW = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [DW-1:0] shift,
	output logic tick
);
	localparam int unsigned CW = (1 << DW) - 1;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic next_tick;
	logic [CW-1:0] mask;

	always_comb begin
		mask = CW'((1 << shift) - 1);
		// Masking keeps a divider change from waiting on a long wrap
		next_count = (count & mask) + CW'(1);
		next_tick = ((count & mask) == mask);
		if (next_tick) begin
			next_count = '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule // tick_prescaler
`default_nettype wire
